// ==== core/byte_lane_ram.v ====
// byte_lane_ram.v: data memory as two byte-wide halves, shared word decode
// assumes one access per cycle from the access unit on the same clock
`timescale 1ns/100ps
`include "dspace_defs.vh"
module byte_lane_ram (
  sys_clk,
  clk_en,
  word_addr,
  we_lo,
  we_hi,
  wdata,
  rdata
);
  input                     sys_clk;
  input                     clk_en;
  input  [`MEM_AW-1:0]      word_addr;
  input                     we_lo;
  input                     we_hi;
  input  [15:0]             wdata;
  output [15:0]             rdata;

  reg [7:0] lo_mem [0:`MEM_WORDS-1];
  reg [7:0] hi_mem [0:`MEM_WORDS-1];

  // separate strobes per half
  always @(posedge sys_clk) begin
    if (clk_en && we_lo) begin
      lo_mem[word_addr] <= wdata[7:0];
    end
    if (clk_en && we_hi) begin
      hi_mem[word_addr] <= wdata[15:8];
    end
  end

  // asynchronous read keeps the load completing in the same cycle
  assign rdata = {hi_mem[word_addr], lo_mem[word_addr]};
endmodule // byte_lane_ram

// ==== core/data_space_access_unit.v ====
// data_space_access_unit.v: load/store path between core working registers and data space
// assumes core issues one request per cycle in its own clock and honours address error trap
`timescale 1ns/100ps
`include "dspace_defs.vh"
module data_space_access_unit (
  sys_clk,
  rst_b,
  clk_en,
  req_valid,
  req_op,
  req_mode,
  req_byte,
  req_reg,
  req_ptr,
  req_field,
  special_rdata,
  special_addr,
  special_we_lo,
  special_we_hi,
  special_wdata,
  done_q,
  rdata_q,
  trap_q,
  trap_addr_q,
  reg_we_q,
  reg_idx_q,
  reg_wdata_q,
  ptr_we_q,
  ptr_idx_q,
  ptr_wdata_q
);
  input         sys_clk;
  input         rst_b;
  input         clk_en;
  input         req_valid;
  input  [2:0]  req_op;
  input  [1:0]  req_mode;
  input         req_byte;
  input  [3:0]  req_reg;
  input  [3:0]  req_ptr;
  input  [15:0] req_field;
  input  [15:0] special_rdata;
  output [15:0] special_addr;
  output        special_we_lo;
  output        special_we_hi;
  output [15:0] special_wdata;
  output        done_q;
  output [15:0] rdata_q;
  output        trap_q;
  output [15:0] trap_addr_q;
  output        reg_we_q;
  output [3:0]  reg_idx_q;
  output [15:0] reg_wdata_q;
  output        ptr_we_q;
  output [3:0]  ptr_idx_q;
  output [15:0] ptr_wdata_q;

  reg        done_q;
  reg [15:0] rdata_q;
  reg        trap_q;
  reg [15:0] trap_addr_q;
  reg        reg_we_q;
  reg [3:0]  reg_idx_q;
  reg [15:0] reg_wdata_q;
  reg        ptr_we_q;
  reg [3:0]  ptr_idx_q;
  reg [15:0] ptr_wdata_q;
  reg        trap_pend_q;
  reg [15:0] wreg [0:15];

  localparam [1:0] ST_RUN  = 2'b01;
  localparam [1:0] ST_TRAP = 2'b10;
  reg [1:0] state_q;

  integer i;

  function region_hit;
    input [15:0] a;
    reg [63:0] map;
    begin
      map = `REGION_MAP;
      region_hit = map[a[10:`REGION_SHIFT]];
    end
  endfunction

  wire [15:0] reg_val = wreg[req_reg];
  wire [15:0] ptr_val = wreg[req_ptr];
  reg  [15:0] eff_addr;
  always @* begin
    case (req_mode)
      `MODE_DIRECT:
        eff_addr = {3'h0, req_field[`NEAR_FIELD_W-1:0]};
      `MODE_FULL:   eff_addr = req_field;
      default:      eff_addr = ptr_val;
    endcase
  end
  wire is_mem_op  = (req_op == `OP_LOAD) || (req_op == `OP_STORE);
  wire word_only  = !is_mem_op;
  wire misaligned = is_mem_op && !req_byte && eff_addr[0];
  wire in_special = eff_addr <= `SPECIAL_TOP;
  wire in_ram     = !in_special && (eff_addr[15:9] == 7'h04);
  wire take       = clk_en && req_valid && (state_q == ST_RUN);
  wire store      = take && (req_op == `OP_STORE) && !misaligned;
  wire lo_lane    = req_byte ? !eff_addr[0] : 1'b1;
  wire hi_lane    = req_byte ? eff_addr[0] : 1'b1;
  wire [15:0] st_data = req_byte ? {reg_val[7:0], reg_val[7:0]} : reg_val;

  wire [15:0] ram_rdata;
  byte_lane_ram u_ram (
    .sys_clk   (sys_clk),
    .clk_en    (clk_en),
    .word_addr (eff_addr[`MEM_AW:1]),
    .we_lo     (store && in_ram && lo_lane),
    .we_hi     (store && in_ram && hi_lane),
    .wdata     (st_data),
    .rdata     (ram_rdata)
  );

  assign special_addr  = {eff_addr[15:1], 1'b0};
  assign special_we_lo = store && in_special && region_hit(eff_addr) && lo_lane;
  assign special_we_hi = store && in_special && region_hit(eff_addr) && hi_lane;
  assign special_wdata = st_data;

  reg [15:0] word_rd;
  always @* begin
    if (in_special) begin
      word_rd = region_hit(eff_addr) ? special_rdata : 16'h0000;
    end else if (in_ram) begin
      word_rd = ram_rdata;
    end else begin
      word_rd = 16'h0000;
    end
  end
  // byte lane pick, always returned on low byte
  wire [7:0]  rd_byte = eff_addr[0] ? word_rd[15:8] : word_rd[7:0];
  wire [15:0] ld_val  = req_byte ? {8'h00, rd_byte} : word_rd;

  reg [15:0] reg_next;
  always @* begin
    case (req_op)
      `OP_LOAD:
        reg_next = req_byte ? {reg_val[15:8], rd_byte} : word_rd;
      `OP_SIGN_EXT: reg_next = {{8{reg_val[7]}}, reg_val[7:0]};
      `OP_ZERO_EXT: reg_next = {8'h00, reg_val[7:0]};
      `OP_SWAP:     reg_next = {reg_val[7:0], reg_val[15:8]};
      default:      reg_next = reg_val;
    endcase
  end
  wire reg_upd = take && (req_op != `OP_STORE) && (is_mem_op || !req_byte || word_only);
  wire ptr_upd = take && is_mem_op && (req_mode == `MODE_POSTINC);
  wire [15:0] ptr_step = req_byte ? `STEP_BYTE : `STEP_WORD;

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_q     <= ST_RUN;
      done_q      <= 1'b0;
      rdata_q     <= 16'h0000;
      trap_q      <= 1'b0;
      trap_addr_q <= 16'h0000;
      trap_pend_q <= 1'b0;
      reg_we_q    <= 1'b0;
      reg_idx_q   <= 4'h0;
      reg_wdata_q <= 16'h0000;
      ptr_we_q    <= 1'b0;
      ptr_idx_q   <= 4'h0;
      ptr_wdata_q <= 16'h0000;
      for (i = 0; i < 16; i = i + 1) begin
        wreg[i] <= 16'h0000;
      end
    end else if (clk_en) begin
      done_q   <= take;
      reg_we_q <= reg_upd;
      ptr_we_q <= ptr_upd;
      trap_q   <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (take) begin
            rdata_q <= ld_val;
            // faulting instruction still finishes before the trap
            if (misaligned) begin
              trap_pend_q <= 1'b1;
              trap_addr_q <= eff_addr;
              state_q     <= ST_TRAP;
            end
            if (reg_upd) begin
              wreg[req_reg] <= reg_next;
              reg_idx_q     <= req_reg;
              reg_wdata_q   <= reg_next;
            end
            // pointer written last so a load through itself keeps the step
            if (ptr_upd) begin
              wreg[req_ptr] <= ptr_val + ptr_step;
              ptr_idx_q     <= req_ptr;
              ptr_wdata_q   <= ptr_val + ptr_step;
            end
          end
        end
        ST_TRAP: begin
          // one-cycle trap pulse; register file left as it was
          trap_q      <= trap_pend_q;
          trap_pend_q <= 1'b0;
          state_q     <= ST_RUN;
        end
        default: state_q <= ST_RUN;
      endcase
    end
  end
endmodule // data_space_access_unit

// ==== core/dspace_defs.vh ====
// dspace_defs.vh: data-space map, address fields, operation codes and region table
// assumes inclusion by bare name from the data space access files
`ifndef DSPACE_DEFS_VH
`define DSPACE_DEFS_VH
`define NEAR_TOP          16'h1fff
`define SPECIAL_TOP       16'h07ff
`define NEAR_FIELD_W      13
`define REGION_SHIFT      5
`define REGION_COUNT      64
`define REGION_MAP        64'h00c0_0000_c00d_007f
`define STEP_BYTE         16'h0001
`define STEP_WORD         16'h0002
`define MEM_WORDS         256
`define MEM_AW            8
`define MODE_DIRECT       2'h0
`define MODE_IND          2'h1
`define MODE_POSTINC      2'h2
`define MODE_FULL         2'h3
`define OP_LOAD           3'h0
`define OP_STORE          3'h1
`define OP_SIGN_EXT       3'h2
`define OP_ZERO_EXT       3'h3
`define OP_SWAP           3'h4
`endif

// ==== dv/data_space_access_unit_tb.sv ====
// self-checking bench for data_space_access_unit
// assumes one-edge answer and two-edge trap as handed over
`timescale 1ns/100ps
module data_space_access_unit_tb;
  logic        sys_clk, rst_b, clk_en, req_valid, req_byte;
  logic [2:0]  req_op;
  logic [1:0]  req_mode;
  logic [3:0]  req_reg, req_ptr, reg_idx_q, ptr_idx_q;
  logic [15:0] req_field, special_rdata, special_addr, special_wdata, rdata_q;
  logic [15:0] trap_addr_q, reg_wdata_q, ptr_wdata_q;
  logic        special_we_lo, special_we_hi, done_q, trap_q, reg_we_q, ptr_we_q;
  int          num_errors = 0;
  int          samples_checked = 0;
  localparam logic [2:0] LD = 3'h0, ST = 3'h1;
  data_space_access_unit i_data_space_access_unit (.*);
  special_reg_model i_special_reg_model (.*);
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    if (num_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    samples_checked++;
    if (s !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      num_errors++;
    end
  endtask
  task automatic req(input logic [2:0] op, input logic [1:0] md, input logic b,
                     input logic [3:0] r, p, input logic [15:0] f);
    @(posedge sys_clk) #1;
    {req_valid, req_op, req_mode, req_byte, req_reg, req_ptr, req_field} =
      {1'b1, op, md, b, r, p, f};
    @(posedge sys_clk) #1;
    req_valid = 0;
    chk("done", {15'h0, done_q}, 16'h1);
  endtask
  task automatic s_special();
    req(LD, 2'h0, 0, 4'h1, 4'h0, 16'he020); chk("near", rdata_q, 16'ha5b5);
    req(LD, 2'h0, 0, 4'h5, 4'h0, 16'h00e0); chk("hole", rdata_q, 16'h0000);
    req(ST, 2'h3, 1, 4'h1, 4'h0, 16'h0021);
    req(ST, 2'h3, 0, 4'h1, 4'h0, 16'h0022);
    req(LD, 2'h3, 0, 4'h2, 4'h0, 16'h0020); chk("lane", rdata_q, 16'hb5b5);
  endtask
  task automatic s_ram();
    req(ST, 2'h3, 0, 4'h1, 4'h0, 16'h0800);
    req(ST, 2'h3, 0, 4'h5, 4'h0, 16'h0802);
    req(ST, 2'h3, 1, 4'h1, 4'h0, 16'h0803);
    req(LD, 2'h3, 0, 4'h3, 4'h0, 16'h0802); chk("bwr", rdata_q, 16'hb500);
    req(LD, 2'h3, 1, 4'h3, 4'h0, 16'h0801); chk("brd", rdata_q, 16'h00a5);
    chk("bld", reg_wdata_q, 16'hb5a5);
    chk("bwe", {15'h0, reg_we_q}, 16'h1);
    chk("bidx", {12'h0, reg_idx_q}, 16'h3);
    req(3'h2, 2'h0, 0, 4'h3, 4'h0, 16'h0); chk("sext", reg_wdata_q, 16'hffa5);
    req(3'h3, 2'h0, 0, 4'h3, 4'h0, 16'h0); chk("zext", reg_wdata_q, 16'h00a5);
  endtask
  task automatic s_postinc();
    req(LD, 2'h2, 1, 4'h6, 4'h4, 16'h0); chk("incb", ptr_wdata_q, 16'h0001);
    chk("pwe", {15'h0, ptr_we_q}, 16'h1);
    chk("pidx", {12'h0, ptr_idx_q}, 16'h4);
    req(LD, 2'h2, 0, 4'h6, 4'h4, 16'h0); chk("incw", ptr_wdata_q, 16'h0003);
    @(posedge sys_clk) #1;
    chk("trap", {15'h0, trap_q}, 16'h1);
    chk("tadr", trap_addr_q, 16'h0001);
  endtask
  task automatic s_freeze();
    // a request while the clock enable is low must leave no trace
    @(posedge sys_clk) #1;
    clk_en = 0;
    {req_valid, req_op, req_mode, req_byte, req_reg, req_field} =
      {1'b1, ST, 2'h3, 1'b0, 4'h5, 16'h0800};
    @(posedge sys_clk) #1;
    chk("frz", {15'h0, done_q}, 16'h0);
    req_valid = 0;
    clk_en = 1;
    req(LD, 2'h3, 0, 4'h7, 4'h0, 16'h0800); chk("frzk", rdata_q, 16'ha5b5);
  endtask
  task automatic s_misstore();
    @(posedge sys_clk) #1;
    {req_valid, req_op, req_mode, req_byte, req_reg, req_field} =
      {1'b1, ST, 2'h3, 1'b0, 4'h1, 16'h0801};
    @(posedge sys_clk) #1;
    chk("mdone", {15'h0, done_q}, 16'h1);
    req_op = LD;
    req_field = 16'h0800;
    @(posedge sys_clk) #1;
    req_valid = 0;
    chk("refuse", {15'h0, done_q}, 16'h0);
    chk("trapw", {15'h0, trap_q}, 16'h1);
    chk("tadrw", trap_addr_q, 16'h0801);
    req(LD, 2'h3, 0, 4'h7, 4'h0, 16'h0800); chk("kept", rdata_q, 16'ha5b5);
  endtask
  initial begin
    {rst_b, req_valid, req_op, req_mode, req_byte, req_reg, req_ptr, req_field} = '0;
    clk_en = 1;
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1;
    s_special();
    s_ram();
    s_postinc();
    s_misstore();
    s_freeze();
    finish_test();
  end
endmodule // data_space_access_unit_tb

// ==== dv/dspace_chk.sv ====
// port checker for data_space_access_unit
// assumes direct-mode requests; indirect addresses are not visible here
`timescale 1ns/100ps
module dspace_chk (
  input logic        sys_clk, rst_b, clk_en, req_valid, req_byte,
  input logic [2:0]  req_op,
  input logic [1:0]  req_mode,
  input logic [15:0] req_field, special_addr, rdata_q,
  input logic        special_we_lo, special_we_hi, done_q, trap_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire        dir = req_mode == 2'h0 || req_mode == 2'h3;
  wire [15:0] ea  = req_mode == 2'h3 ? req_field : {3'h0, req_field[12:0]};
  wire        mis = req_valid && clk_en && dir && !req_byte && req_op < 3'h2 && ea[0];
  wire        rq  = req_valid && clk_en;
  a_done_take: assert property (rq && !$past(mis) |=> done_q)
    else $error("done missing");
  a_idle_quiet: assert property (!(rq && !$past(mis)) |=> !done_q)
    else $error("stray done");
  a_trap_mis: assert property (mis && !$past(mis) ##1 clk_en |=> trap_q)
    else $error("trap missing");
  a_trap_after: assert property (trap_q |-> $past(done_q))
    else $error("trap before finish");
  a_mis_nowrite: assert property (mis && req_op == 3'h1 |-> !special_we_lo && !special_we_hi)
    else $error("misaligned write");
  a_byte_lane: assert property (rq && dir && req_byte && req_op == 3'h1
    |-> !(ea[0] ? special_we_lo : special_we_hi)) else $error("wrong lane");
  a_lanes_split: assert property (special_we_lo != special_we_hi |-> req_byte)
    else $error("split strobe");
  a_word_both: assert property (rq && !$past(mis) && dir && !req_byte && req_op == 3'h1
    && ea < 16'h0040 && !ea[0] |-> special_we_lo && special_we_hi)
    else $error("word strobe");
  a_byte_hi0: assert property (rq && !$past(mis) && req_op == 3'h0 && req_byte
    |=> rdata_q[15:8] == 8'h00) else $error("byte high");
  a_ea_decode: assert property (rq && dir && ea < 16'h0800
    |-> special_addr == {ea[15:1], 1'b0}) else $error("decode");
endmodule // dspace_chk
bind data_space_access_unit dspace_chk i_dspace_chk (.*);

// ==== dv/special_reg_model.sv ====
// special register block model behind the access unit
// assumes word index from special_addr and byte strobes on sys_clk
`timescale 1ns/100ps
module special_reg_model (
  input  logic        sys_clk, clk_en, special_we_lo, special_we_hi,
  input  logic [15:0] special_addr, special_wdata,
  output logic [15:0] special_rdata
);
  logic [15:0] mem [0:1023];
  // nonzero fill, so holes must be masked by the unit
  initial for (int i = 0; i < 1024; i++) mem[i] = 16'ha5a5 ^ 16'(i);
  assign special_rdata = mem[special_addr[10:1]];
  always @(posedge sys_clk) begin
    if (clk_en && special_we_lo) mem[special_addr[10:1]][7:0] <= special_wdata[7:0];
    if (clk_en && special_we_hi) mem[special_addr[10:1]][15:8] <= special_wdata[15:8];
  end
endmodule // special_reg_model
